//--- dlc_pkg.sv
// Constants, register map and carrier types of the debug link config block.
// Assumes one 25 MHz clock shared by the link layer and this block.
package dlc_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [3:0] OFS_REVISION   = 4'h0;
	localparam logic [3:0] OFS_ERROR      = 4'h1;
	localparam logic [3:0] OFS_CTRL_A     = 4'h2;
	localparam logic [3:0] OFS_CTRL_B     = 4'h3;
	localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
	localparam logic [3:0] OFS_RESET_REQ  = 4'h8;
	localparam logic [3:0] OFS_CLOCK_SEL  = 4'h9;
	localparam logic [3:0] OFS_SYS_CTRL   = 4'hA;
	localparam logic [3:0] OFS_SYS_STATUS = 4'hB;
	localparam logic [3:0] OFS_CRC_STATUS = 4'hC;

	// Field positions
	localparam int REV_LSB       = 4;
	localparam int A_GAP_BIT     = 7;
	localparam int A_PARITY_BIT  = 5;
	localparam int A_TIMEOUT_BIT = 4;
	localparam int A_REPLY_BIT   = 3;
	localparam int B_NACK_BIT    = 4;
	localparam int B_COLL_BIT    = 3;
	localparam int B_DISABLE_BIT = 2;
	localparam int KEY_UROW_BIT  = 5;
	localparam int KEY_NVM_BIT   = 4;
	localparam int KEY_ERASE_BIT = 3;
	localparam int SC_UROW_BIT   = 1;
	localparam int SC_CLOCK_BIT  = 0;
	localparam int SS_RESET_BIT  = 5;
	localparam int SS_SLEEP_BIT  = 4;
	localparam int SS_NVM_BIT    = 3;
	localparam int SS_UROW_BIT   = 2;
	localparam int SS_LOCK_BIT   = 0;

	// Index of each bit of the system status input vector
	localparam int SYS_IN_W     = 5;
	localparam int SI_RESET     = 0;
	localparam int SI_SLEEP     = 1;
	localparam int SI_NVM_READY = 2;
	localparam int SI_UROW_READY = 3;
	localparam int SI_LOCKED    = 4;

	// Error codes
	localparam logic [2:0] ERR_NONE       = 3'h0;
	localparam logic [2:0] ERR_PARITY     = 3'h1;
	localparam logic [2:0] ERR_FRAME      = 3'h2;
	localparam logic [2:0] ERR_TIMEOUT    = 3'h3;
	localparam logic [2:0] ERR_CLOCK_REC  = 3'h4;
	localparam logic [2:0] ERR_RESERVED   = 3'h5;
	localparam logic [2:0] ERR_BUS        = 3'h6;
	localparam logic [2:0] ERR_CONTENTION = 3'h7;

	// Reset values and codes
	localparam logic [7:0] RESET_HOLD_CODE = 8'h59;
	localparam logic [7:0] RESET_RUN_CODE  = 8'h00;
	localparam logic [1:0] CLKSEL_RESERVED = 2'h0;
	localparam logic [1:0] CLKSEL_DEFAULT  = 2'h3;
	localparam logic [2:0] GUARD_RESERVED  = 3'h7;
	localparam logic [7:0] GUARD_MAX       = 8'h80;
	localparam logic [1:0] GAP_IDLE_BITS   = 2'h2;
	localparam int TIMEOUT_CYCLES = 65536;
	localparam int TIMEOUT_W      = 17;
	localparam int GUARD_W        = 8;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dlc_reg_req_t;

	typedef struct packed {
		logic [1:0] gap_bits;
		logic       parity_check_off;
		logic       timeout_check_off;
		logic       reply_signature_off;
		logic       negative_ack_off;
		logic       collision_check_off;
		logic [2:0] turnaround_guard_select;
		logic [1:0] link_clock_divider;
	} dlc_link_cfg_t;

endpackage

//--- dlc_wait_timer.sv
// Loadable down counter: busy while counting, one-cycle done at the end.
// Assumes an active-low reset with synchronous release and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module dlc_wait_timer #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         abort,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			done  <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (load) begin
				count <= load_val;
			end else if (abort) begin
				count <= '0;
			end else if (count != '0) begin
				count <= count - W'(1);
				done  <= (count == W'(1));
			end
		end
	end

	assign busy = (count != '0);
endmodule // dlc_wait_timer
`default_nettype wire

//--- dlc_config_regs.sv
// Configuration, status and key registers of the single-wire debug link.
// Assumes the link layer decodes register instructions onto REG_REQ and
// that the system status inputs come from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module dlc_config_regs
	import dlc_pkg::*;
#(
	parameter logic [3:0] REVISION     = 4'h1, // Arbitrary value
	parameter int         TIMEOUT_CNT  = dlc_pkg::TIMEOUT_CYCLES
) (
	input  wire logic                  REF_CLK,
	input  wire logic                  RST_B,
	input  wire logic                  CE,
	input  wire dlc_pkg::dlc_reg_req_t REG_REQ,
	output logic [7:0]                 REG_RDATA,
	input  wire logic                  ERR_VALID,
	input  wire logic [2:0]            ERR_CODE,
	input  wire logic                  ACC_START,
	input  wire logic                  ACC_DONE,
	input  wire logic                  TURNAROUND,
	output logic                       TX_READY,
	input  wire logic                  XFER_BUSY,
	output logic                       NACK_REQ,
	input  wire logic                  KEY_UROW,
	input  wire logic                  KEY_NVM,
	input  wire logic                  KEY_ERASE,
	input  wire logic                  LINK_ENABLE,
	input  wire logic [4:0]            SYS_STATUS_IN,
	input  wire logic [2:0]            CRC_STATUS,
	output dlc_pkg::dlc_link_cfg_t     LINK_CFG,
	output logic                       SYS_RESET,
	output logic                       CLOCK_HOLD,
	output logic                       UROW_DONE,
	output logic                       LINK_DISABLE
);
	import dlc_pkg::*;
	logic                rst_meta, rst_n;
	logic [SYS_IN_W-1:0] sys_meta, sys_sync;
	logic                nvm_ready_d, reset_seen;
	logic                gap_enable, parity_check_off;
	logic                timeout_check_off, reply_signature_off;
	logic                negative_ack_off, collision_check_off;
	logic [2:0]          turnaround_guard_select, error_code_field;
	logic                user_row_key_flag, nvm_write_key_flag;
	logic                erase_key_flag, system_clock_hold;
	logic [7:0]          system_reset_code, next_rdata;
	logic [1:0]          link_clock_divider;
	logic [GUARD_W-1:0]  guard_cycles;
	logic                timeout_done, guard_busy;
	logic                wr_en, rd_en, disable_req, reset_issue;
	logic                nvm_ready_rise, err_accept;

	// Reset release through two flops
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// System-domain status crosses into this clock
	for (genvar i = 0; i < SYS_IN_W; i++) begin : g_sync
		always_ff @(posedge REF_CLK or negedge rst_n) begin
			if (!rst_n) begin
				sys_meta[i] <= 1'b0;
				sys_sync[i] <= 1'b0;
			end else if (CE) begin
				sys_meta[i] <= SYS_STATUS_IN[i];
				sys_sync[i] <= sys_meta[i];
			end
		end
	end

	// Only link instructions arrive here; no CPU port exists
	assign wr_en = CE && REG_REQ.wr;
	assign rd_en = CE && REG_REQ.rd;
	assign disable_req = wr_en && (REG_REQ.addr == OFS_CTRL_B)
		&& REG_REQ.wdata[B_DISABLE_BIT];
	assign reset_issue = wr_en && (REG_REQ.addr == OFS_RESET_REQ)
		&& (REG_REQ.wdata == RESET_HOLD_CODE);
	assign nvm_ready_rise = sys_sync[SI_NVM_READY] && !nvm_ready_d;

	// Link option registers
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			{gap_enable, parity_check_off, timeout_check_off} <= '0;
			{reply_signature_off, turnaround_guard_select} <= '0;
			{negative_ack_off, collision_check_off} <= '0;
		end else if (disable_req) begin
			{gap_enable, parity_check_off, timeout_check_off} <= '0;
			{reply_signature_off, turnaround_guard_select} <= '0;
			{negative_ack_off, collision_check_off} <= '0;
		end else if (wr_en && REG_REQ.addr == OFS_CTRL_A) begin
			gap_enable              <= REG_REQ.wdata[A_GAP_BIT];
			parity_check_off        <= REG_REQ.wdata[A_PARITY_BIT];
			timeout_check_off       <= REG_REQ.wdata[A_TIMEOUT_BIT];
			reply_signature_off     <= REG_REQ.wdata[A_REPLY_BIT];
			turnaround_guard_select <= REG_REQ.wdata[2:0];
		end else if (wr_en && REG_REQ.addr == OFS_CTRL_B) begin
			negative_ack_off    <= REG_REQ.wdata[B_NACK_BIT];
			collision_check_off <= REG_REQ.wdata[B_COLL_BIT];
		end
	end

	// Filtered error events; disabled parity and collision checks never report, a link time-out code still does
	assign err_accept = ERR_VALID && ERR_CODE != ERR_NONE
		&& ERR_CODE != ERR_RESERVED
		&& !(ERR_CODE == ERR_PARITY && parity_check_off)
		&& !(ERR_CODE == ERR_CONTENTION && collision_check_off);

	// Error code: a new error wins over the read clear
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			error_code_field <= ERR_NONE;
		end else if (CE) begin
			if (disable_req)
				error_code_field <= ERR_NONE;
			else if (timeout_done && !timeout_check_off)
				error_code_field <= ERR_TIMEOUT;
			else if (err_accept)
				error_code_field <= ERR_CODE;
			else if (rd_en && REG_REQ.addr == OFS_ERROR)
				error_code_field <= ERR_NONE;
		end
	end

	// Key flags: decode sets, documented events clear
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			{user_row_key_flag, nvm_write_key_flag, erase_key_flag} <= '0;
		end else if (disable_req) begin
			{user_row_key_flag, nvm_write_key_flag, erase_key_flag} <= '0;
		end else if (CE) begin
			if (KEY_UROW)
				user_row_key_flag <= 1'b1;
			else if (wr_en && REG_REQ.addr == OFS_KEY_STATUS
				&& REG_REQ.wdata[KEY_UROW_BIT])
				user_row_key_flag <= 1'b0;
			if (KEY_NVM)
				nvm_write_key_flag <= 1'b1;
			else if (nvm_ready_rise)
				nvm_write_key_flag <= 1'b0;
			if (KEY_ERASE)
				erase_key_flag <= 1'b1;
			else if (reset_issue)
				erase_key_flag <= 1'b0;
		end
	end

	// Reset request, clock select, clock hold; none touch rst_n
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			system_reset_code  <= RESET_RUN_CODE;
			link_clock_divider <= CLKSEL_DEFAULT;
			system_clock_hold  <= 1'b0;
		end else if (disable_req) begin
			system_clock_hold  <= 1'b0;
			link_clock_divider <= CLKSEL_DEFAULT;
		end else if (CE) begin
			if (LINK_ENABLE) begin
				system_clock_hold  <= 1'b1;
				link_clock_divider <= CLKSEL_DEFAULT;
			end else if (wr_en && REG_REQ.addr == OFS_CLOCK_SEL
				&& REG_REQ.wdata[1:0] != CLKSEL_RESERVED) begin
				link_clock_divider <= REG_REQ.wdata[1:0];
			end else if (wr_en && REG_REQ.addr == OFS_SYS_CTRL) begin
				system_clock_hold <= REG_REQ.wdata[SC_CLOCK_BIT];
			end
			if (wr_en && REG_REQ.addr == OFS_RESET_REQ)
				system_reset_code <= REG_REQ.wdata;
		end
	end

	// Pulses, sticky reset-seen flag and edge history
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			{NACK_REQ, UROW_DONE, LINK_DISABLE} <= '0;
			{reset_seen, nvm_ready_d} <= '0;
		end else if (CE) begin
			NACK_REQ     <= reset_issue && XFER_BUSY && !negative_ack_off;
			UROW_DONE    <= wr_en && REG_REQ.addr == OFS_SYS_CTRL
				&& REG_REQ.wdata[SC_UROW_BIT] && user_row_key_flag;
			LINK_DISABLE <= disable_req;
			nvm_ready_d  <= sys_sync[SI_NVM_READY];
			if (sys_sync[SI_RESET] || SYS_RESET)
				reset_seen <= 1'b1;
			else if (rd_en && REG_REQ.addr == OFS_SYS_STATUS)
				reset_seen <= 1'b0;
		end
	end

	// Guard length: 128 shifted right by the code; reserved code 7 gives 128
	assign guard_cycles = (turnaround_guard_select == GUARD_RESERVED)
		? GUARD_MAX : (GUARD_MAX >> turnaround_guard_select);

	dlc_wait_timer #(.W(GUARD_W)) u_guard (
		.clk      (REF_CLK),
		.rst_n    (rst_n),
		.ce       (CE),
		.load     (TURNAROUND),
		.load_val (guard_cycles),
		.abort    (disable_req),
		.busy     (guard_busy),
		.done     ()
	);
	dlc_wait_timer #(.W(TIMEOUT_W)) u_timeout (
		.clk      (REF_CLK),
		.rst_n    (rst_n),
		.ce       (CE),
		.load     (ACC_START),
		.load_val (TIMEOUT_W'(TIMEOUT_CNT)),
		.abort    (ACC_DONE || disable_req),
		.busy     (),
		.done     (timeout_done)
	);

	// Read mux
	always_comb begin
		next_rdata = 8'h00;
		unique case (REG_REQ.addr)
			OFS_REVISION:   next_rdata[7:REV_LSB] = REVISION;
			OFS_ERROR:      next_rdata[2:0] = error_code_field;
			OFS_CTRL_A: begin
				next_rdata[A_GAP_BIT]     = gap_enable;
				next_rdata[A_PARITY_BIT]  = parity_check_off;
				next_rdata[A_TIMEOUT_BIT] = timeout_check_off;
				next_rdata[A_REPLY_BIT]   = reply_signature_off;
				next_rdata[2:0]           = turnaround_guard_select;
			end
			OFS_CTRL_B: next_rdata[B_NACK_BIT:B_COLL_BIT]
				= {negative_ack_off, collision_check_off};
			OFS_KEY_STATUS: next_rdata[KEY_UROW_BIT:KEY_ERASE_BIT]
				= {user_row_key_flag, nvm_write_key_flag, erase_key_flag};
			OFS_RESET_REQ:  next_rdata = system_reset_code;
			OFS_CLOCK_SEL:  next_rdata[1:0] = link_clock_divider;
			OFS_SYS_CTRL:   next_rdata[SC_CLOCK_BIT] = system_clock_hold;
			OFS_SYS_STATUS: begin
				next_rdata[SS_RESET_BIT] = reset_seen;
				next_rdata[SS_SLEEP_BIT] = sys_sync[SI_SLEEP];
				next_rdata[SS_NVM_BIT]   = sys_sync[SI_NVM_READY];
				next_rdata[SS_UROW_BIT]  = sys_sync[SI_UROW_READY];
				next_rdata[SS_LOCK_BIT]  = sys_sync[SI_LOCKED];
			end
			OFS_CRC_STATUS: next_rdata[2:0] = CRC_STATUS;
			default:        next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n)
			REG_RDATA <= 8'h00;
		else if (rd_en)
			REG_RDATA <= next_rdata;
	end

	assign LINK_CFG.gap_bits = gap_enable ? GAP_IDLE_BITS : 2'h0;
	assign LINK_CFG.parity_check_off        = parity_check_off;
	assign LINK_CFG.timeout_check_off       = timeout_check_off;
	assign LINK_CFG.reply_signature_off     = reply_signature_off;
	assign LINK_CFG.negative_ack_off        = negative_ack_off;
	assign LINK_CFG.collision_check_off     = collision_check_off;
	assign LINK_CFG.turnaround_guard_select = turnaround_guard_select;
	assign LINK_CFG.link_clock_divider      = link_clock_divider;
	assign SYS_RESET  = (system_reset_code == RESET_HOLD_CODE);
	assign CLOCK_HOLD = system_clock_hold;
	assign TX_READY   = !guard_busy;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!rst_n);
	sequence s_wr(logic [3:0] a, logic q);
		wr_en && REG_REQ.addr == a && q;
	endsequence
	sequence s_guard2;
		(TURNAROUND && CE && turnaround_guard_select == 3'h6)
		##1 (CE && !TURNAROUND) ##1 (CE && !TURNAROUND);
	endsequence
	AST_REV_READ: assert property (rd_en && REG_REQ.addr == OFS_REVISION
		|=> REG_RDATA[7:REV_LSB] == REVISION)
		else $error("revision nibble wrong");
	AST_ERR_CLEAR: assert property (rd_en && REG_REQ.addr == OFS_ERROR
		&& !err_accept && !timeout_done && !disable_req
		|=> error_code_field == ERR_NONE)
		else $error("error code not cleared on read");
	AST_TIMEOUT: assert property (CE && timeout_done && !timeout_check_off
		&& !disable_req |=> error_code_field == ERR_TIMEOUT)
		else $error("time-out not reported");
	AST_PARITY_OFF: assert property (parity_check_off
		&& error_code_field != ERR_PARITY |=> error_code_field != ERR_PARITY)
		else $error("parity error reported while disabled");
	AST_GUARD: assert property (s_guard2 |=> TX_READY)
		else $error("guard of two cycles overran");
	AST_HOLD: assert property (s_wr(OFS_RESET_REQ,
		REG_REQ.wdata == RESET_HOLD_CODE)
		##1 !(wr_en && REG_REQ.addr == OFS_RESET_REQ) |-> SYS_RESET [*2])
		else $error("system reset not held");
	AST_ERASE_CLR: assert property (reset_issue && !KEY_ERASE
		&& !disable_req |=> !erase_key_flag)
		else $error("erase key flag not cleared");
	AST_DISABLE: assert property (disable_req |=> !CLOCK_HOLD
		&& LINK_CFG.link_clock_divider == CLKSEL_DEFAULT
		&& !nvm_write_key_flag && LINK_CFG.gap_bits == 2'h0 && LINK_DISABLE)
		else $error("disable left state behind");
	AST_NVM_CLR: assert property (CE && nvm_ready_rise && !KEY_NVM
		&& !disable_req |=> !nvm_write_key_flag)
		else $error("programming key flag not cleared");
	AST_CLKSEL_RSV: assert property (s_wr(OFS_CLOCK_SEL, !LINK_ENABLE
		&& REG_REQ.wdata[1:0] == CLKSEL_RESERVED && !disable_req)
		|=> $stable(link_clock_divider))
		else $error("reserved clock select taken");
endmodule // dlc_config_regs
`default_nettype wire

//--- dlc_link_model.sv
// Debugger side of the register link: issues one-cycle register requests.
// Assumes the bench calls its task and shares the 25 MHz REF_CLK.
`timescale 1ns/1ps
`default_nettype none
module dlc_link_model
	import dlc_pkg::*;
#(
	parameter time D = 2
) (
	input  wire logic              clk,
	output dlc_pkg::dlc_reg_req_t  req
);
	import dlc_pkg::*;

	initial req = '0;

	// One request, held over exactly one taking edge
	task automatic access(input logic w, input logic [3:0] a,
			input logic [7:0] d);
		@(posedge clk);
		#D;
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		#D;
		req = '0;
	endtask
endmodule // dlc_link_model
`default_nettype wire

//--- debug_link_config_status_tb.sv
// Self-checking bench of the debug link configuration registers.
// Assumes dlc_pkg, dlc_config_regs and dlc_link_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module debug_link_config_status_tb;
	import dlc_pkg::*;
	localparam time D = 2;
	logic REF_CLK = 0, RST_B = 0, CE = 1;
	dlc_reg_req_t REG_REQ;
	logic [7:0] REG_RDATA;
	logic ERR_VALID = 0, ACC_START = 0, ACC_DONE = 0, TURNAROUND = 0;
	logic [2:0] ERR_CODE = 0, CRC_STATUS = 0;
	logic TX_READY, XFER_BUSY = 0, NACK_REQ, LINK_ENABLE = 0;
	logic KEY_UROW = 0, KEY_NVM = 0, KEY_ERASE = 0;
	logic [4:0] SYS_STATUS_IN = 0;
	dlc_link_cfg_t LINK_CFG;
	logic SYS_RESET, CLOCK_HOLD, UROW_DONE, LINK_DISABLE;
	int mismatches = 0, checks = 0, cyc = 0, n;
	logic [7:0] exp_q[$];
	logic [7:0] v;
	logic [7:0] rexp;
	logic [31:0] seed = 32'hde38_1b69;

	always #20 REF_CLK = ~REF_CLK;

	dlc_link_model #(.D(D)) i_dbg (.clk(REF_CLK), .req(REG_REQ));

	dlc_config_regs #(.REVISION(4'h9), .TIMEOUT_CNT(16)) i_dut (
		.REF_CLK(REF_CLK), .RST_B(RST_B), .CE(CE), .REG_REQ(REG_REQ),
		.REG_RDATA(REG_RDATA), .ERR_VALID(ERR_VALID), .ERR_CODE(ERR_CODE),
		.ACC_START(ACC_START), .ACC_DONE(ACC_DONE),
		.TURNAROUND(TURNAROUND), .TX_READY(TX_READY),
		.XFER_BUSY(XFER_BUSY), .NACK_REQ(NACK_REQ), .KEY_UROW(KEY_UROW),
		.KEY_NVM(KEY_NVM), .KEY_ERASE(KEY_ERASE),
		.LINK_ENABLE(LINK_ENABLE), .SYS_STATUS_IN(SYS_STATUS_IN),
		.CRC_STATUS(CRC_STATUS), .LINK_CFG(LINK_CFG),
		.SYS_RESET(SYS_RESET), .CLOCK_HOLD(CLOCK_HOLD),
		.UROW_DONE(UROW_DONE), .LINK_DISABLE(LINK_DISABLE));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic end_of_test();
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_dbg.access(1'b1, a, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_dbg.access(1'b0, a, 8'h00);
	endtask

	task automatic pulse(ref logic s);
		@(posedge REF_CLK);
		#D s = 1;
		@(posedge REF_CLK);
		#D s = 0;
	endtask

	task automatic err(input logic [2:0] c);
		ERR_CODE = c;
		pulse(ERR_VALID);
	endtask

	// Read data lands on the taking edge and is checked 1 ns after it
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			$display("unexpected at %0t: time limit reached", $time);
			end_of_test();
		end else if (REG_REQ.rd === 1'b1 && CE === 1'b1
				&& RST_B === 1'b1) begin
			#1;
			if (exp_q.size() == 0) begin
				mismatches++;
				$display("unexpected at %0t: read with nothing expected",
					$time);
			end else begin
				rexp = exp_q.pop_front();
				`CHK(REG_RDATA, rexp)
			end
		end
	end

	initial begin
		static logic [3:0] ra[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8,
			4'h9, 4'h4};
		static logic [7:0] re[8] = '{8'h90, 0, 0, 0, 0, 0, 8'h03, 0};
		repeat (4) @(posedge REF_CLK);
		`CHK(TX_READY, 1'b1)
		`CHK(LINK_CFG.link_clock_divider, CLKSEL_DEFAULT)
		#D RST_B = 1;
		repeat (3) @(posedge REF_CLK);
		for (int i = 0; i < 8; i++)
			rd(ra[i], re[i]);
		rd(4'hD, 8'h00);
		for (int c = 0; c < 8; c++) begin
			err(c[2:0]);
			rd(OFS_ERROR, (c == 5) ? 8'h00 : 8'(c));
			rd(OFS_ERROR, 8'h00);
		end
		wr(OFS_CTRL_A, 8'h20);
		err(ERR_PARITY);
		rd(OFS_ERROR, 8'h00);
		wr(OFS_CTRL_B, 8'h08);
		err(ERR_CONTENTION);
		rd(OFS_ERROR, 8'h00);
		wr(OFS_CTRL_B, 8'h00);
		err(ERR_CONTENTION);
		rd(OFS_ERROR, 8'h07);
		v = 8'(rnd()) & 8'hBF;
		wr(OFS_CTRL_A, v);
		`CHK(LINK_CFG.gap_bits, v[7] ? GAP_IDLE_BITS : 2'h0)
		`CHK(LINK_CFG.parity_check_off, v[5])
		`CHK(LINK_CFG.timeout_check_off, v[4])
		`CHK(LINK_CFG.reply_signature_off, v[3])
		`CHK(LINK_CFG.turnaround_guard_select, v[2:0])
		rd(OFS_CTRL_A, v);
		for (int s = 0; s < 7; s++) begin
			wr(OFS_CTRL_A, 8'(s));
			pulse(TURNAROUND);
			for (n = 0; TX_READY !== 1'b0 && n < 3; n++)
				@(posedge REF_CLK) #D;
			for (n = 0; TX_READY === 1'b0 && n < 300; n++)
				@(posedge REF_CLK) #D;
			`CHK(n, 128 >> s)
		end
		for (int m = 0; m < 3; m++) begin
			wr(OFS_CTRL_A, (m == 1) ? 8'h10 : 8'h00);
			pulse(ACC_START);
			if (m == 2)
				pulse(ACC_DONE);
			repeat (20) @(posedge REF_CLK);
			rd(OFS_ERROR, (m == 0) ? 8'h03 : 8'h00);
		end
		pulse(KEY_ERASE);
		rd(OFS_KEY_STATUS, 8'h08);
		XFER_BUSY = 1;
		wr(OFS_RESET_REQ, RESET_HOLD_CODE);
		`CHK(SYS_RESET, 1'b1)
		`CHK(NACK_REQ, 1'b1)
		rd(OFS_KEY_STATUS, 8'h00);
		rd(OFS_REVISION, 8'h90);
		wr(OFS_RESET_REQ, RESET_RUN_CODE);
		`CHK(SYS_RESET, 1'b0)
		wr(OFS_RESET_REQ, 8'h33);
		`CHK(SYS_RESET, 1'b0)
		wr(OFS_CTRL_B, 8'h10);
		wr(OFS_RESET_REQ, RESET_HOLD_CODE);
		`CHK(NACK_REQ, 1'b0)
		wr(OFS_RESET_REQ, RESET_RUN_CODE);
		XFER_BUSY = 0;
		pulse(KEY_UROW);
		pulse(KEY_NVM);
		rd(OFS_KEY_STATUS, 8'h30);
		wr(OFS_SYS_CTRL, 8'h03);
		`CHK(UROW_DONE, 1'b1)
		`CHK(CLOCK_HOLD, 1'b1)
		wr(OFS_KEY_STATUS, 8'h20);
		rd(OFS_KEY_STATUS, 8'h10);
		SYS_STATUS_IN = 5'b1_0100;
		repeat (4) @(posedge REF_CLK);
		rd(OFS_KEY_STATUS, 8'h00);
		rd(OFS_SYS_STATUS, 8'h29);
		SYS_STATUS_IN = 5'b0_0100;
		repeat (4) @(posedge REF_CLK);
		rd(OFS_SYS_STATUS, 8'h08);
		for (int k = 1; k < 5; k++) begin
			wr(OFS_CLOCK_SEL, 8'(k & 3));
			rd(OFS_CLOCK_SEL, (k == 4) ? 8'h03 : 8'(k));
		end
		CRC_STATUS = 3'(rnd());
		rd(OFS_CRC_STATUS, {5'h00, CRC_STATUS});
		CE = 0;
		wr(OFS_CTRL_A, 8'h80);
		CE = 1;
		rd(OFS_CTRL_A, 8'h00);
		wr(OFS_CTRL_A, 8'hB8);
		wr(OFS_CLOCK_SEL, 8'h01);
		pulse(KEY_ERASE);
		err(ERR_FRAME);
		wr(OFS_CTRL_B, 8'h1C);
		`CHK(LINK_DISABLE, 1'b1)
		`CHK(CLOCK_HOLD, 1'b0)
		`CHK(LINK_CFG, dlc_link_cfg_t'(12'h003))
		rd(OFS_CTRL_A, 8'h00);
		rd(OFS_CTRL_B, 8'h00);
		rd(OFS_KEY_STATUS, 8'h00);
		rd(OFS_ERROR, 8'h00);
		pulse(LINK_ENABLE);
		`CHK(CLOCK_HOLD, 1'b1)
		wr(OFS_SYS_CTRL, 8'h00);
		`CHK(CLOCK_HOLD, 1'b0)
		repeat (3) @(posedge REF_CLK);
		end_of_test();
	end
endmodule // debug_link_config_status_tb
`default_nettype wire
